// ---- logic/clkrg_pkg.sv ----
package clkrg_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_PERIOD_NS    = 10;
    localparam int unsigned STATUS_HIST_CYCLES = 2;
    localparam int unsigned READY_MIN_CYCLES   = 2;

    // ------------------------------------------------------------------
    // Reset values and levels
    // ------------------------------------------------------------------
    localparam logic PCLK_RESET_LEVEL   = 1'b0;
    localparam logic PIN_HIGH           = 1'b1;
    localparam logic READY_PULL_LEVEL   = 1'b0;
    localparam logic RESET_REQ_ASSERTED = 1'b0;

    // ------------------------------------------------------------------
    // Ready generator states, Gray along idle -> hold -> active
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RDY_IDLE   = 2'h0,
        RDY_HOLD   = 2'h1,
        RDY_ACTIVE = 2'h3
    } clkrg_rdy_state_t;

endpackage

// ---- logic/clkrg_top.sv ----
`timescale 1ns/10ps
// Contract
// RL1 - Strap low picks crystal oscillator, strap high picks external frequency input.
// RL2 - System clock output runs at the frequency of the selected source.
// RL3 - Source must run at twice the processor internal clock rate.
// RL4 - System clock is twice the processor internal rate, shared with support parts.
// RL5 - Peripheral clock is half the system clock with even duty cycle.
// RL6 - Peripheral clock phase aligned by end of first bus cycle after reset.
// RL7 - Async ready request counts only when its low qualifier is asserted.
// RL8 - Async ready pair may change anytime and is synchronised before use.
// RL9 - Sync ready request counts only when its low qualifier is asserted.
// RL10 - Sync ready sources must change synchronously with the system clock.
// RL11 - Ready output is active low, pull-down only, relying on external pull-up.
// RL12 - Bus status inputs steer both peripheral clock phase and ready output.
// RL13 - Undriven bus status inputs read high through internal pull-ups.
// RL14 - Active high system reset is generated from the low reset request.
// RL15 - While system reset is asserted, ready output is driven active.
// RL16 - Reset request may change asynchronously and is synchronised first.
// RL17 - Peripheral clock held high when a status was low the two prior cycles.
// RL18 - Reset request change reaches reset output after one or two cycles.
// RL19 - Ready asserts on a qualified low pair and stays at least two cycles.
// RL20 - Ready released when any status sampled low, starting cycle not ready.
// RL21 - Async ready pair and reset request pass two synchroniser flops.
module clkrg_top (
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_freq_select,
    input  wire logic i_crystal_pins,
    input  wire logic i_external_frequency_in,
    input  wire logic i_async_ready_request_n,
    input  wire logic i_async_ready_qualifier_n,
    input  wire logic i_sync_ready_request_n,
    input  wire logic i_sync_ready_qualifier_n,
    input  wire logic i_bus_status0_n,
    input  wire logic i_bus_status0_driven,
    input  wire logic i_bus_status1_n,
    input  wire logic i_bus_status1_driven,
    input  wire logic i_reset_request_n,
    output logic      o_system_clock,
    output logic      o_peripheral_clock,
    output logic      o_ready_n_out,
    output logic      o_ready_n_oe,
    output logic      o_system_reset
);

    // ------------------------------------------------------------------
    // Clock source selection
    // ------------------------------------------------------------------
    // Internal logic runs on i_clock, which the system ties to this output;
    // the source itself must already run at twice the processor rate.
    always_comb begin
        o_system_clock = i_freq_select ? i_external_frequency_in
                                       : i_crystal_pins; // RL1 RL2 RL4 RL3
    end

    // ------------------------------------------------------------------
    // Bus status pins
    // ------------------------------------------------------------------
    logic status0_n;
    logic status1_n;
    logic status_low;

    always_comb begin
        status0_n  = i_bus_status0_driven ? i_bus_status0_n : clkrg_pkg::PIN_HIGH; // RL13
        status1_n  = i_bus_status1_driven ? i_bus_status1_n : clkrg_pkg::PIN_HIGH; // RL13
        status_low = !status0_n || !status1_n; // RL12
    end

    // ------------------------------------------------------------------
    // Reset request synchroniser
    // ------------------------------------------------------------------
    // The second flop doubles as the output stage, giving a one to two cycle
    // response instead of three.
    logic reset_req_meta;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            reset_req_meta <= clkrg_pkg::RESET_REQ_ASSERTED;
            o_system_reset <= 1'b1;
        end else begin
            reset_req_meta <= i_reset_request_n; // RL16 RL21
            o_system_reset <= !reset_req_meta; // RL14 RL18
        end
    end

    // ------------------------------------------------------------------
    // Async ready synchroniser
    // ------------------------------------------------------------------
    logic async_ready_request_n_meta;
    logic async_ready_request_n_sync;
    logic aqual_meta;
    logic aqual_sync;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            async_ready_request_n_meta  <= clkrg_pkg::PIN_HIGH;
            async_ready_request_n_sync  <= clkrg_pkg::PIN_HIGH;
            aqual_meta <= clkrg_pkg::PIN_HIGH;
            aqual_sync <= clkrg_pkg::PIN_HIGH;
        end else begin
            async_ready_request_n_meta  <= i_async_ready_request_n; // RL8 RL21
            async_ready_request_n_sync  <= async_ready_request_n_meta;
            aqual_meta <= i_async_ready_qualifier_n; // RL8 RL21
            aqual_sync <= aqual_meta;
        end
    end

    // ------------------------------------------------------------------
    // Peripheral clock
    // ------------------------------------------------------------------
    logic [clkrg_pkg::STATUS_HIST_CYCLES-1:0] status_hist;
    logic                                     status_held;

    always_comb begin
        status_held = &status_hist;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            status_hist <= '0;
        end else begin
            status_hist <= {status_hist[clkrg_pkg::STATUS_HIST_CYCLES-2:0], status_low};
        end
    end

    // Forcing high through the status phase stretches the high time, which
    // pulls the divider into step with the processor on its first cycle.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_peripheral_clock <= clkrg_pkg::PCLK_RESET_LEVEL;
        end else if (status_held) begin
            o_peripheral_clock <= 1'b1; // RL17 RL6 RL12
        end else begin
            o_peripheral_clock <= !o_peripheral_clock; // RL5
        end
    end

    // ------------------------------------------------------------------
    // Ready generator
    // ------------------------------------------------------------------
    clkrg_pkg::clkrg_rdy_state_t rdy_state;
    clkrg_pkg::clkrg_rdy_state_t next_rdy_state;
    logic                        async_ok;
    logic                        sync_ok;
    logic                        ready_hit;

    always_comb begin
        async_ok  = !async_ready_request_n_sync && !aqual_sync; // RL7
        sync_ok   = !i_sync_ready_request_n && !i_sync_ready_qualifier_n; // RL9 RL10
        // Async pair wins; sync pair only looked at outside the status phase.
        ready_hit = o_peripheral_clock && (async_ok || (sync_ok && !status_low)); // RL19
    end

    always_comb begin
        next_rdy_state = rdy_state;
        if (o_system_reset) begin
            next_rdy_state = clkrg_pkg::RDY_ACTIVE; // RL15
        end else if (status_low) begin
            next_rdy_state = clkrg_pkg::RDY_IDLE; // RL20
        end else begin
            case (rdy_state)
                clkrg_pkg::RDY_IDLE: begin
                    if (ready_hit) begin
                        next_rdy_state = clkrg_pkg::RDY_HOLD; // RL19
                    end
                end
                clkrg_pkg::RDY_HOLD: begin
                    next_rdy_state = clkrg_pkg::RDY_ACTIVE; // RL19
                end
                clkrg_pkg::RDY_ACTIVE: begin
                    if (o_peripheral_clock && !ready_hit) begin
                        next_rdy_state = clkrg_pkg::RDY_IDLE;
                    end
                end
                default: begin
                    next_rdy_state = clkrg_pkg::RDY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rdy_state <= clkrg_pkg::RDY_ACTIVE;
        end else begin
            rdy_state <= next_rdy_state;
        end
    end

    // Open collector: the pin only ever pulls low; release means float.
    always_comb begin
        o_ready_n_out = clkrg_pkg::READY_PULL_LEVEL; // RL11
        o_ready_n_oe  = (rdy_state != clkrg_pkg::RDY_IDLE); // RL11
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_clock_select;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_system_clock == (i_freq_select ? i_external_frequency_in : i_crystal_pins);
    endproperty
    a_clock_select: assert property (p_clock_select) else $error("clock source wrong"); // RL1

    property p_pclk_toggle;
        @(posedge i_clock) disable iff (i_sys_rst)
        !status_held |=> o_peripheral_clock != $past(o_peripheral_clock);
    endproperty
    a_pclk_toggle: assert property (p_pclk_toggle) else $error("pclk did not toggle"); // RL5

    sequence s_status_two;
        status_low ##1 status_low;
    endsequence

    property p_pclk_forced;
        @(posedge i_clock) disable iff (i_sys_rst)
        // History flop plus output flop: the forced level shows two edges later
        s_status_two |=> ##1 o_peripheral_clock;
    endproperty
    a_pclk_forced: assert property (p_pclk_forced) else $error("pclk not held high"); // RL17

    property p_reset_follows;
        @(posedge i_clock) disable iff (i_sys_rst)
        $fell(i_reset_request_n) ##1 !i_reset_request_n |-> ##[0:1] o_system_reset;
    endproperty
    a_reset_follows: assert property (p_reset_follows) else $error("reset late"); // RL18

    property p_reset_release;
        @(posedge i_clock) disable iff (i_sys_rst)
        i_reset_request_n [*3] |-> !o_system_reset;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("reset stuck"); // RL14

    property p_ready_in_reset;
        @(posedge i_clock) disable iff (i_sys_rst)
        o_system_reset |=> o_ready_n_oe;
    endproperty
    a_ready_in_reset: assert property (p_ready_in_reset) else $error("ready not forced"); // RL15

    property p_ready_float;
        @(posedge i_clock) disable iff (i_sys_rst)
        (status_low && !o_system_reset) |=> !o_ready_n_oe;
    endproperty
    a_ready_float: assert property (p_ready_float) else $error("ready not floated"); // RL20

    sequence s_ready_rise;
        !o_ready_n_oe ##1 (o_ready_n_oe && !status_low && !o_system_reset);
    endsequence

    property p_ready_min;
        @(posedge i_clock) disable iff (i_sys_rst)
        s_ready_rise |=> o_ready_n_oe;
    endproperty
    a_ready_min: assert property (p_ready_min) else $error("ready too short"); // RL19

    property p_async_ready;
        @(posedge i_clock) disable iff (i_sys_rst)
        (!o_ready_n_oe && o_peripheral_clock && async_ok && !status_low && !o_system_reset)
            |=> o_ready_n_oe;
    endproperty
    a_async_ready: assert property (p_async_ready) else $error("async ready missed"); // RL7

    property p_no_unqualified;
        @(posedge i_clock) disable iff (i_sys_rst)
        (!o_ready_n_oe && aqual_sync && i_sync_ready_qualifier_n && !o_system_reset)
            |=> !o_ready_n_oe;
    endproperty
    a_no_unqualified: assert property (p_no_unqualified) else $error("unqualified ready"); // RL9

endmodule // clkrg_top

// ---- verification/clkrg_bus_model.sv ----
`timescale 1ns/10ps
// --------------------
// Processor, ready sources, reset net
// --------------------
module clkrg_bus_model (
    input  wire logic       i_clock,
    input  wire logic [1:0] i_status_cmd,
    input  wire logic       i_status_drive,
    input  wire logic [1:0] i_sync_cmd,
    input  wire logic [1:0] i_async_cmd,
    input  wire logic       i_reset_cmd,
    output logic            o_crystal,
    output logic            o_ext_freq,
    output logic [1:0]      o_status_n,
    output logic            o_status_driven,
    output logic [1:0]      o_sync_n,
    output logic [1:0]      o_async_n,
    output logic            o_reset_n
);
    initial begin
        {o_crystal, o_ext_freq, o_status_driven} = 3'h1;
        {o_status_n, o_sync_n, o_async_n, o_reset_n} = 7'h7f;
    end
    // Unrelated periods so the two sources cannot be confused
    always #5 o_crystal = ~o_crystal;
    always #7 o_ext_freq = ~o_ext_freq;
    // Released status lines wander; only the pull-up may hold them high
    always @(negedge i_clock) begin
        o_status_n      <= i_status_drive ? i_status_cmd : ~o_status_n;
        o_status_driven <= i_status_drive;
        o_sync_n        <= i_sync_cmd;
        o_async_n       <= #3 i_async_cmd;
        o_reset_n       <= #4 i_reset_cmd;
    end
endmodule // clkrg_bus_model

// ---- verification/tb_clkrg_top.sv ----
`timescale 1ns/10ps
module tb_clkrg_top;
    logic       i_clock = 1'b0;
    logic       i_sys_rst = 1'b1;
    logic       fsel = 1'b0;
    logic [1:0] st_cmd = 2'h3;
    logic       st_drv_cmd = 1'b1;
    logic [1:0] sy_cmd = 2'h3;
    logic [1:0] as_cmd = 2'h3;
    logic       rs_cmd = 1'b1;
    logic       xtal, external_frequency_in, st_drv, res_n, sclk, pclk, r_out, r_oe, sreset;
    logic [1:0] st_n, sy_n, as_n;
    wire        rdy = r_oe ? r_out : 1'b1;
    int         num_errors = 0;
    int         n_tests = 0;

    always #5 i_clock = ~i_clock;

    clkrg_bus_model model (.i_clock(i_clock), .i_status_cmd(st_cmd),
        .i_status_drive(st_drv_cmd), .i_sync_cmd(sy_cmd), .i_async_cmd(as_cmd),
        .i_reset_cmd(rs_cmd), .o_crystal(xtal), .o_ext_freq(external_frequency_in),
        .o_status_n(st_n), .o_status_driven(st_drv), .o_sync_n(sy_n),
        .o_async_n(as_n), .o_reset_n(res_n));

    clkrg_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_freq_select(fsel),
        .i_crystal_pins(xtal), .i_external_frequency_in(external_frequency_in),
        .i_async_ready_request_n(as_n[1]), .i_async_ready_qualifier_n(as_n[0]),
        .i_sync_ready_request_n(sy_n[1]), .i_sync_ready_qualifier_n(sy_n[0]),
        .i_bus_status0_n(st_n[0]), .i_bus_status0_driven(st_drv),
        .i_bus_status1_n(st_n[1]), .i_bus_status1_driven(st_drv),
        .i_reset_request_n(res_n), .o_system_clock(sclk), .o_peripheral_clock(pclk),
        .o_ready_n_out(r_out), .o_ready_n_oe(r_oe), .o_system_reset(sreset));

    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    function automatic logic sig(input int s);
        return s == 0 ? rdy : (s == 1 ? sreset : pclk);
    endfunction

    task automatic await(input string nm, input int s, input logic e, input int lim);
        for (int n = 0; n < lim && sig(s) !== e; n++)
            @(negedge i_clock);
        chk(nm, e, sig(s));
        if (sig(s) !== e)
            final_report();
    endtask

    task automatic toggles(input int n);
        logic p;
        repeat (n) begin
            p = pclk;
            @(negedge i_clock);
            chk("pclk", ~p, pclk);
        end
    endtask

    task automatic s_clock();
        for (int s = 0; s < 2; s++) begin
            @(negedge i_clock);
            fsel <= s[0];
            // Odd offsets keep samples clear of source transitions
            repeat (4) begin
                #3.3;
                chk("system clock", s ? external_frequency_in : xtal, sclk);
            end
        end
        @(negedge i_clock);
    endtask

    task automatic s_pclk();
        st_cmd <= 2'h0;
        st_drv_cmd <= 1'b0;
        @(negedge i_clock);
        toggles(4);
        st_drv_cmd <= 1'b1;
        repeat (5) @(negedge i_clock);
        repeat (3) begin
            chk("pclk held", 1'b1, pclk);
            @(negedge i_clock);
        end
        st_cmd <= 2'h3;
        repeat (3) @(negedge i_clock);
        toggles(4);
    endtask

    task automatic end_cycle(input logic [1:0] st);
        st_cmd <= st;
        @(negedge i_clock);
        await("ready float", 0, 1'b1, 4);
        // Sources drop only now, so status alone must have floated ready
        sy_cmd <= 2'h3;
        as_cmd <= 2'h3;
        // Status stays low until the async release has crossed its synchroniser
        repeat (3) @(negedge i_clock);
        st_cmd <= 2'h3;
        repeat (2) @(negedge i_clock);
    endtask

    task automatic s_sync();
        sy_cmd <= 2'h1;
        repeat (8) @(negedge i_clock);
        chk("ready unqualified", 1'b1, rdy);
        await("pclk", 2, 1'b0, 3);
        sy_cmd <= 2'h0;
        @(negedge i_clock);
        await("ready sync", 0, 1'b0, 3);
        @(negedge i_clock);
        chk("ready held", 1'b0, rdy);
    endtask

    task automatic s_async();
        as_cmd <= 2'h1;
        repeat (8) @(negedge i_clock);
        chk("ready unqualified", 1'b1, rdy);
        as_cmd <= 2'h0;
        await("ready async", 0, 1'b0, 10);
    endtask

    task automatic s_resreq();
        rs_cmd <= 1'b0;
        await("reset out", 1, 1'b1, 4);
        await("ready forced", 0, 1'b0, 2);
        rs_cmd <= 1'b1;
        await("reset out", 1, 1'b0, 4);
    endtask

    initial begin
        repeat (12) @(negedge i_clock);
        chk("reset out", 1'b1, sreset);
        chk("ready forced", 1'b0, rdy);
        i_sys_rst = 1'b0;
        await("reset out", 1, 1'b0, 4);
        s_clock();
        s_pclk();
        end_cycle(2'h2);
        s_sync();
        end_cycle(2'h1);
        s_async();
        end_cycle(2'h2);
        s_resreq();
        final_report();
    end
endmodule // tb_clkrg_top
